// *** servo_ref_pkg.sv ***
// Constants, types and helpers shared by the servo reference-input logic.
// How it works
// [R01] Zero clamp input low, slow reference: hold position.
// [R02] Clamp holds captured position, corrects any displacement.
// [R03] Zero clamp input unallocated until allocation set.
// [R04] Mode A: aux input low plus slow reference clamps.
// [R05] Speed mode: match output low on coincidence.
// [R06] Coincidence when speed error below match window.
// [R07] Position mode: that terminal shows positioning done; code drives it on terminal OUT_TERM_RESET, not the allocated one.
// [R08] Output allocation moves speed match to another terminal.
// [R09] Mode value 1 selects pulse-train position control.
// [R10] Pulse form: sign/pulse, cw/ccw, quadrature x1/x2/x4.
// [R11] Multiplication applies only to quadrature forms.
// [R12] Direction high counts forward, low counts reverse.
// [R13] Inversion field flips direction and pulse independently.
// [R14] Phase B leading phase A means forward.
// [R15] Host keeps sign/pulse rates within 500/200 kpps.
// [R16] Host keeps quadrature rates within 500/400/200 kpps.
// [R17] Decoded pulses accumulate into signed position reference.
package servo_ref_pkg;

	// ****************************************************************
	// Register map and field layout.
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ALLOC = 8'h04;
	localparam logic [7:0] ADDR_LIMIT = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_POSREF = 8'h10;
	localparam logic [7:0] ADDR_RESTART = 8'h14;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_FORM_LSB = 4;
	localparam int CTRL_INV_LSB = 8;
	localparam int ALLOC_A_LSB = 0;
	localparam int ALLOC_B_LSB = 4;
	localparam int ALLOC_OUT_LSB = 8;
	localparam int LIMIT_THR_LSB = 0;
	localparam int LIMIT_WIN_LSB = 16;
	localparam int STAT_CLAMP_BIT = 0;
	localparam int STAT_MATCH_BIT = 1;
	localparam int STAT_DONE_BIT = 2;
	localparam int STAT_MODE_LSB = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************************************
	// Reset values and limits.
	// ****************************************************************
	localparam logic [11:0] THR_RESET = 12'h00a;
	localparam logic [11:0] THR_MAX = 12'hbb8;
	localparam logic [6:0] WIN_RESET = 7'h0a;
	localparam logic [6:0] WIN_MAX = 7'h64;
	localparam logic [2:0] PIN_NONE = 3'h0;
	localparam logic [1:0] OUT_TERM_RESET = 2'h0;
	localparam logic [16:0] DONE_BAND = 17'h00001;

	// ****************************************************************
	// Modes and carriers.
	// ****************************************************************
	typedef enum logic [3:0] {
		MODE_SPEED = 4'h0,
		MODE_POS = 4'h1,
		MODE_CLAMP = 4'ha
	} mode_e;

	typedef enum logic [2:0] {
		FORM_DIR = 3'h0,
		FORM_CWCCW = 3'h1,
		FORM_QX1 = 3'h2,
		FORM_QX2 = 3'h3,
		FORM_QX4 = 3'h4
	} form_e;

	typedef struct packed {
		mode_e mode;
		form_e form;
		logic [1:0] inv;
	} cfg_s;

	localparam cfg_s CFG_RESET = '{mode: MODE_SPEED, form: FORM_DIR, inv: 2'h0};

	// Magnitude of a signed 17-bit difference.
	function automatic logic [16:0] absVal(input logic signed [16:0] v);
		absVal = v[16] ? 17'(-v) : 17'(v);
	endfunction

endpackage

// *** pulse_decoder.sv ***
// Pulse-train reference decoder for sign/pulse, cw/ccw and quadrature forms.
`timescale 1ns/1ps
module pulse_decoder
	import servo_ref_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic lineA,
	input wire logic lineB,
	input wire form_e form,
	input wire logic [1:0] inv,
	output logic stepValid,
	output logic stepFwd
);

	typedef struct packed {
		logic primed;
		logic prevA;
		logic prevB;
		logic stepValid;
		logic stepFwd;
	} dec_s;

	dec_s st_r;
	dec_s st_nxt;
	logic a;
	logic b;
	logic chA;
	logic chB;

	// Line inversion: bit 1 flips the pulse line, bit 0 the direction line.
	assign a = lineA ^ inv[1]; // see [R13]
	assign b = lineB ^ inv[0]; // see [R13]
	assign chA = a ^ st_r.prevA;
	assign chB = b ^ st_r.prevB;

	// Edge decode; lines are sampled every 100 ns, far faster than the host limits.
	always_comb begin
		st_nxt = st_r;
		st_nxt.primed = 1'b1;
		st_nxt.prevA = a;
		st_nxt.prevB = b;
		st_nxt.stepValid = 1'b0;
		st_nxt.stepFwd = 1'b0;
		if (st_r.primed) begin // see [R15] [R16]
			case (form) // see [R10] [R11]
				FORM_DIR: begin
					if (chA && a) begin
						st_nxt.stepValid = 1'b1;
						st_nxt.stepFwd = b; // see [R12]
					end
				end
				FORM_CWCCW: begin
					if (chA && a && !(chB && b)) begin
						st_nxt.stepValid = 1'b1;
						st_nxt.stepFwd = 1'b1;
					end else if (chB && b && !(chA && a)) begin
						st_nxt.stepValid = 1'b1;
					end
				end
				FORM_QX1: begin
					if (chA && a && !chB) begin
						st_nxt.stepValid = 1'b1;
						st_nxt.stepFwd = b; // see [R14]
					end
				end
				FORM_QX2: begin
					if (chA && !chB) begin
						st_nxt.stepValid = 1'b1;
						st_nxt.stepFwd = st_r.prevA ^ b; // see [R14]
					end
				end
				FORM_QX4: begin
					if (chA ^ chB) begin
						st_nxt.stepValid = 1'b1;
						st_nxt.stepFwd = st_r.prevA ^ b; // see [R14]
					end
				end
				default: begin
					st_nxt.stepValid = 1'b0;
				end
			endcase
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign stepValid = st_r.stepValid;
	assign stepFwd = st_r.stepFwd;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	property p_dir_sign;
		@(posedge clk) disable iff (!rst_b)
		(st_r.primed && form == FORM_DIR && chA && a) |=> (stepValid && stepFwd == $past(b));
	endproperty
	a_dir_sign: assert property (p_dir_sign) else $error("sign/pulse step wrong"); // see [R12]

	property p_quad_fwd;
		@(posedge clk) disable iff (!rst_b)
		(st_r.primed && form == FORM_QX4 && !st_r.prevA && !st_r.prevB && !a && b)
			|=> (stepValid && stepFwd);
	endproperty
	a_quad_fwd: assert property (p_quad_fwd) else $error("quadrature lead not forward"); // see [R14]

	property p_x1_only_a_rise;
		@(posedge clk) disable iff (!rst_b)
		(form == FORM_QX1 && !(chA && a)) |=> !stepValid;
	endproperty
	a_x1_only_a_rise: assert property (p_x1_only_a_rise) else $error("x1 extra count"); // see [R11]

endmodule

// *** servo_ref_input.sv ***
// Servo reference-input logic: zero clamp, speed match, pulse position reference.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module servo_ref_input
	import servo_ref_pkg::*;
#(
	parameter int POS_W = 32,
	parameter int NUM_IN = 4,
	parameter int NUM_OUT = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pulseLine,
	input wire logic dirLine,
	input wire logic auxCtlIn_b,
	input wire logic [NUM_IN-1:0] ctlIn_b,
	input wire logic signed [15:0] speedRef,
	input wire logic signed [15:0] motorSpeed,
	input wire logic signed [POS_W-1:0] motorPos,
	output logic holdEn,
	output logic signed [POS_W-1:0] holdCmd,
	output logic signed [POS_W-1:0] posRef,
	output logic [NUM_OUT-1:0] termOut_b
);

	typedef struct packed {
		logic awReady;
		logic wReady;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [1:0] rResp;
		logic [31:0] rData;
		logic awHeld;
		logic wHeld;
		logic [7:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		cfg_s pend;
		cfg_s act;
		logic [2:0] allocA;
		logic [2:0] allocB;
		logic [1:0] outSel;
		logic [11:0] thr;
		logic [6:0] win;
		logic clamp;
		logic signed [POS_W-1:0] clampPos;
		logic signed [POS_W-1:0] holdCmd;
		logic signed [POS_W-1:0] posRef;
		logic [NUM_OUT-1:0] termOut_b;
	} st_s;

	localparam st_s ST_RESET = '{
		awReady: 1'b1, wReady: 1'b1, bValid: 1'b0, bResp: RESP_OKAY,
		arReady: 1'b1, rValid: 1'b0, rResp: RESP_OKAY, rData: '0,
		awHeld: 1'b0, wHeld: 1'b0, awAddr: '0, wData: '0, wStrb: '0,
		pend: CFG_RESET, act: CFG_RESET, allocA: PIN_NONE, allocB: PIN_NONE,
		outSel: OUT_TERM_RESET, thr: THR_RESET, win: WIN_RESET, clamp: 1'b0,
		clampPos: '0, holdCmd: '0, posRef: '0, termOut_b: '1};

	st_s st_r;
	st_s st_nxt;
	logic stepValid;
	logic stepFwd;

	// Reads a low-active control input through an allocation index; zero means unallocated.
	function automatic logic pinLevel_b(input logic [2:0] idx, input logic [NUM_IN-1:0] pins);
		pinLevel_b = 1'b1;
		for (int i = 0; i < NUM_IN; i++) begin
			if (idx == 3'(i + 1)) begin
				pinLevel_b = pins[i];
			end
		end
	endfunction

	// Merges a written word into an old one under the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[i*8 +: 8] = d[i*8 +: 8];
			end
		end
	endfunction

	// ****************************************************************
	// Pulse-train decoding.
	// ****************************************************************
	pulse_decoder u_dec (
		.clk(clk),
		.rst_b(rst_b),
		.lineA(pulseLine),
		.lineB(dirLine),
		.form(st_r.act.form),
		.inv(st_r.act.inv),
		.stepValid(stepValid),
		.stepFwd(stepFwd)
	);

	// ****************************************************************
	// Next-state logic.
	// ****************************************************************
	logic [31:0] ctrlWord;
	logic [31:0] allocWord;
	logic [31:0] limitWord;
	logic [31:0] statWord;
	logic [31:0] wWord;
	logic [16:0] refMag;
	logic [16:0] speedErr;
	logic [16:0] posErr;
	logic zeroClamp_b;
	logic clampCond;
	logic match;
	logic posDone;
	logic isPos;

	// Register views and the block's own conditions.
	always_comb begin
		ctrlWord = '0;
		ctrlWord[CTRL_MODE_LSB +: 4] = st_r.pend.mode;
		ctrlWord[CTRL_FORM_LSB +: 3] = st_r.pend.form;
		ctrlWord[CTRL_INV_LSB +: 2] = st_r.pend.inv;
		allocWord = '0;
		allocWord[ALLOC_A_LSB +: 3] = st_r.allocA;
		allocWord[ALLOC_B_LSB +: 3] = st_r.allocB;
		allocWord[ALLOC_OUT_LSB +: 2] = st_r.outSel;
		limitWord = '0;
		limitWord[LIMIT_THR_LSB +: 12] = st_r.thr;
		limitWord[LIMIT_WIN_LSB +: 7] = st_r.win;
		refMag = absVal(17'(speedRef));
		speedErr = absVal(17'(motorSpeed) - 17'(speedRef));
		posErr = absVal(17'(st_r.posRef - motorPos));
		isPos = (st_r.act.mode == MODE_POS);
		// Allocation A wins when both map the zero clamp input.
		zeroClamp_b = (st_r.allocA != PIN_NONE) ? pinLevel_b(st_r.allocA, ctlIn_b)
			: pinLevel_b(st_r.allocB, ctlIn_b); // see [R03]
		case (st_r.act.mode)
			MODE_SPEED: clampCond = !zeroClamp_b && (refMag < 17'(st_r.thr)); // see [R01]
			MODE_CLAMP: clampCond = !auxCtlIn_b && (refMag < 17'(st_r.thr)); // see [R04]
			default: clampCond = 1'b0;
		endcase
		match = (speedErr < 17'(st_r.win)); // see [R06]
		posDone = (posErr <= DONE_BAND);
		statWord = '0;
		statWord[STAT_CLAMP_BIT] = st_r.clamp;
		statWord[STAT_MATCH_BIT] = match;
		statWord[STAT_DONE_BIT] = posDone;
		statWord[STAT_MODE_LSB +: 4] = st_r.act.mode;
	end

	// Bus slave, configuration, clamp, counter and terminals.
	always_comb begin
		st_nxt = st_r;
		wWord = '0;
		// Write channels are taken in either order and held until both are in.
		if (s_axi_awvalid && st_r.awReady) begin
			st_nxt.awHeld = 1'b1;
			st_nxt.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wReady) begin
			st_nxt.wHeld = 1'b1;
			st_nxt.wData = s_axi_wdata;
			st_nxt.wStrb = s_axi_wstrb;
		end
		if (st_r.bValid && s_axi_bready) begin
			st_nxt.bValid = 1'b0;
		end
		if (st_r.awHeld && st_r.wHeld && !st_r.bValid) begin
			st_nxt.awHeld = 1'b0;
			st_nxt.wHeld = 1'b0;
			st_nxt.bValid = 1'b1;
			st_nxt.bResp = RESP_OKAY;
			case (st_r.awAddr)
				ADDR_CTRL: begin
					wWord = merge(ctrlWord, st_r.wData, st_r.wStrb);
					st_nxt.pend.mode = mode_e'(wWord[CTRL_MODE_LSB +: 4]);
					st_nxt.pend.form = form_e'(wWord[CTRL_FORM_LSB +: 3]);
					st_nxt.pend.inv = wWord[CTRL_INV_LSB +: 2];
				end
				ADDR_ALLOC: begin
					wWord = merge(allocWord, st_r.wData, st_r.wStrb);
					st_nxt.allocA = wWord[ALLOC_A_LSB +: 3];
					st_nxt.allocB = wWord[ALLOC_B_LSB +: 3];
					st_nxt.outSel = wWord[ALLOC_OUT_LSB +: 2]; // see [R08]
				end
				ADDR_LIMIT: begin
					// Limits act at once; values past the range saturate.
					wWord = merge(limitWord, st_r.wData, st_r.wStrb);
					st_nxt.thr = (wWord[LIMIT_THR_LSB +: 12] > THR_MAX) ? THR_MAX
						: wWord[LIMIT_THR_LSB +: 12];
					st_nxt.win = (wWord[LIMIT_WIN_LSB +: 7] > WIN_MAX) ? WIN_MAX
						: wWord[LIMIT_WIN_LSB +: 7];
				end
				ADDR_RESTART: begin
					// Mode, form and inversion only change here, as on a restart.
					if (st_r.wStrb[0] && st_r.wData[0]) begin
						st_nxt.act = st_r.pend; // see [R09] [R13]
						st_nxt.clamp = 1'b0;
						st_nxt.posRef = '0;
					end
				end
				ADDR_STATUS, ADDR_POSREF: st_nxt.bResp = RESP_OKAY;
				default: st_nxt.bResp = RESP_SLVERR;
			endcase
		end
		st_nxt.awReady = !st_nxt.awHeld && !st_nxt.bValid;
		st_nxt.wReady = !st_nxt.wHeld && !st_nxt.bValid;
		// Read channel: one read at a time, data registered.
		if (st_r.rValid && s_axi_rready) begin
			st_nxt.rValid = 1'b0;
		end
		if (s_axi_arvalid && st_r.arReady) begin
			st_nxt.rValid = 1'b1;
			st_nxt.rResp = RESP_OKAY;
			case (s_axi_araddr)
				ADDR_CTRL: st_nxt.rData = ctrlWord;
				ADDR_ALLOC: st_nxt.rData = allocWord;
				ADDR_LIMIT: st_nxt.rData = limitWord;
				ADDR_STATUS: st_nxt.rData = statWord;
				ADDR_POSREF: st_nxt.rData = 32'(st_r.posRef);
				ADDR_RESTART: st_nxt.rData = '0;
				default: begin
					st_nxt.rData = '0;
					st_nxt.rResp = RESP_SLVERR;
				end
			endcase
		end
		st_nxt.arReady = !st_nxt.rValid;
		// Zero clamp captures the position on entry and then pulls back to it.
		if (clampCond && !st_r.clamp) begin
			st_nxt.clamp = 1'b1;
			st_nxt.clampPos = motorPos; // see [R02]
			st_nxt.holdCmd = '0;
		end else if (clampCond) begin
			st_nxt.holdCmd = st_r.clampPos - motorPos; // see [R02]
		end else begin
			st_nxt.clamp = 1'b0;
			st_nxt.holdCmd = '0;
		end
		// Position reference counter, only fed in position mode.
		if (isPos && stepValid) begin
			st_nxt.posRef = stepFwd ? st_r.posRef + POS_W'(1) : st_r.posRef - POS_W'(1); // see [R17]
		end
		// Output terminals, low active; idle terminals stay high.
		st_nxt.termOut_b = '1;
		if (isPos) begin
			st_nxt.termOut_b[OUT_TERM_RESET] = !posDone; // see [R07]
		end else begin
			st_nxt.termOut_b[st_r.outSel] = !match; // see [R05] [R08]
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Every output comes straight from the state register.
	assign s_axi_awready = st_r.awReady;
	assign s_axi_wready = st_r.wReady;
	assign s_axi_bvalid = st_r.bValid;
	assign s_axi_bresp = st_r.bResp;
	assign s_axi_arready = st_r.arReady;
	assign s_axi_rvalid = st_r.rValid;
	assign s_axi_rresp = st_r.rResp;
	assign s_axi_rdata = st_r.rData;
	assign holdEn = st_r.clamp;
	assign holdCmd = st_r.holdCmd;
	assign posRef = st_r.posRef;
	assign termOut_b = st_r.termOut_b;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	property p_clamp_entry;
		@(posedge clk) disable iff (!rst_b)
		(clampCond && !st_r.clamp) |=> (holdEn && st_r.clampPos == $past(motorPos));
	endproperty
	a_clamp_entry: assert property (p_clamp_entry) else $error("clamp entry missed"); // see [R01]

	property p_clamp_pull;
		@(posedge clk) disable iff (!rst_b)
		(st_r.clamp && clampCond) |=> (holdCmd == $past(st_r.clampPos) - $past(motorPos));
	endproperty
	a_clamp_pull: assert property (p_clamp_pull) else $error("clamp correction wrong"); // see [R02]

	property p_unallocated;
		@(posedge clk) disable iff (!rst_b)
		(st_r.allocA == PIN_NONE && st_r.allocB == PIN_NONE && st_r.act.mode == MODE_SPEED)
			|=> !holdEn;
	endproperty
	a_unallocated: assert property (p_unallocated) else $error("clamp without pin"); // see [R03]

	property p_aux_clamp;
		@(posedge clk) disable iff (!rst_b)
		(st_r.act.mode == MODE_CLAMP && auxCtlIn_b) |=> !holdEn;
	endproperty
	a_aux_clamp: assert property (p_aux_clamp) else $error("mode A clamped with aux high"); // see [R04]

	property p_match_out;
		@(posedge clk) disable iff (!rst_b)
		(!isPos && speedErr < 17'(st_r.win)) |=> !termOut_b[$past(st_r.outSel)];
	endproperty
	a_match_out: assert property (p_match_out) else $error("speed match not shown"); // see [R05]

	property p_done_out;
		@(posedge clk) disable iff (!rst_b)
		(isPos && posErr > DONE_BAND) |=> termOut_b[OUT_TERM_RESET];
	endproperty
	a_done_out: assert property (p_done_out) else $error("positioning done too early"); // see [R07]

	property p_count;
		@(posedge clk) disable iff (!rst_b)
		(isPos && stepValid && !(st_r.awHeld && st_r.wHeld))
			|=> (posRef == $past(posRef) + ($past(stepFwd) ? 1 : -1));
	endproperty
	a_count: assert property (p_count) else $error("position count wrong"); // see [R17]

	sequence s_write_done;
		st_r.awHeld && st_r.wHeld && !st_r.bValid ##1 s_axi_bvalid;
	endsequence
	property p_bresp_hold;
		@(posedge clk) disable iff (!rst_b)
		s_write_done |-> (s_axi_bvalid && !s_axi_awready) [*1] ##1 (s_axi_bvalid || $past(s_axi_bready));
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write answer dropped");

endmodule

// *** pulse_host_model.sv ***
// Host motion controller model that issues reference pulse trains.
`timescale 1ns/1ps
module pulse_host_model
	import servo_ref_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic go,
	input wire form_e form,
	input wire logic fwd,
	input wire logic [1:0] inv,
	input wire logic [7:0] count,
	output logic lineA,
	output logic lineB,
	output logic busy
);
	// Drives both lines after an edge and holds them for g edges.
	task automatic step(input logic a, input logic b, input int g);
		lineA <= a;
		lineB <= b;
		repeat (g) @(posedge clk);
	endtask

	// Runs one train per go request; phase widths keep the line rate legal.
	initial begin
		int g;
		lineA = 1'b0;
		lineB = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (go && rst_b) begin
				busy <= 1'b1;
				g = (form == FORM_QX4) ? 13 : (form == FORM_QX2) ? 7 : (form == FORM_QX1) ? 5 : 10;
				if (form == FORM_DIR) begin
					step(inv[1], fwd ^ inv[0], g);
					repeat (count) begin
						step(~inv[1], fwd ^ inv[0], g);
						step(inv[1], fwd ^ inv[0], g);
					end
				end else if (form == FORM_CWCCW) begin
					repeat (count) begin
						step(fwd, ~fwd, g);
						step(1'b0, 1'b0, g);
					end
				end else begin
					repeat (count) begin
						step(~fwd, fwd, g);
						step(1'b1, 1'b1, g);
						step(fwd, ~fwd, g);
						step(1'b0, 1'b0, g);
					end
				end
				busy <= 1'b0;
			end
		end
	end
endmodule

// *** servo_reference_input_logic_bench.sv ***
// Self-checking bench for the servo reference-input logic.
`timescale 1ns/1ps
module servo_reference_input_logic_bench
	import servo_ref_pkg::*;
;
	// ************************************************************
	// Signals and instances.
	// ************************************************************
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, auxCtlIn_b = 1'b1, go = 1'b0, hostFwd = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, hostCount = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] ctlIn_b = 4'hf;
	logic [1:0] hostInv = 2'h0;
	logic signed [15:0] speedRef = 16'sh0, motorSpeed = 16'sh0;
	logic signed [31:0] motorPos = 32'sh0;
	form_e hostForm = FORM_DIR;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic pulseLine, dirLine, holdEn, hostBusy;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] termOut_b;
	logic signed [31:0] holdCmd, posRef;
	int failCount = 0, samplesChecked = 0, cycles = 0;

	servo_ref_input #(.POS_W(32), .NUM_IN(4), .NUM_OUT(4)) i_dut (
		.clk(clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.pulseLine(pulseLine), .dirLine(dirLine), .auxCtlIn_b(auxCtlIn_b), .ctlIn_b(ctlIn_b),
		.speedRef(speedRef), .motorSpeed(motorSpeed), .motorPos(motorPos), .holdEn(holdEn),
		.holdCmd(holdCmd), .posRef(posRef), .termOut_b(termOut_b));

	pulse_host_model i_host (
		.clk(clk), .rst_b(rst_b), .go(go), .form(hostForm), .fwd(hostFwd), .inv(hostInv),
		.count(hostCount), .lineA(pulseLine), .lineB(dirLine), .busy(hostBusy));

	// Makes the 10 MHz clock.
	initial begin
		forever #50 clk = ~clk;
	end

	// Cuts a hung run short and reports it as a mismatch.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failCount++;
			summarize();
		end
	end

	// ************************************************************
	// Bus, compare and stimulus tasks.
	// ************************************************************
	task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			failCount++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic waitCyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Writes one word; address and data are released each when taken, bready stays high.
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic awOk, wOk;
		awOk = 1'b0;
		wOk = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(awOk && wOk)) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) begin
				awOk = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wOk = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axiWrite(a, d, r);
		checkVal({30'h0, r}, {30'h0, RESP_OKAY});
	endtask

	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!(s_axi_arvalid && s_axi_arready));
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	task automatic rdCheck(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		axiRead(a, d, r);
		checkVal(d, exp);
		checkVal({30'h0, r}, {30'h0, er});
	endtask

	// Writes the pending configuration and applies it with a restart.
	task automatic setCfg(input mode_e m, input form_e f, input logic [1:0] iv);
		wr(ADDR_CTRL, {22'h0, iv, 1'b0, f, m});
		wr(ADDR_RESTART, 32'h1);
	endtask

	// Has the host send one train and waits until posRef has settled.
	task automatic hostRun(input form_e f, input logic fw, input logic [1:0] iv, input logic [7:0] n);
		hostForm <= f;
		hostFwd <= fw;
		hostInv <= iv;
		hostCount <= n;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do @(posedge clk); while (hostBusy);
		waitCyc(4);
	endtask

	// ************************************************************
	// Scenarios.
	// ************************************************************
	task automatic testRegs();
		logic [1:0] r;
		rdCheck(ADDR_LIMIT, 32'h000a000a, RESP_OKAY);
		rdCheck(ADDR_ALLOC, 32'h0, RESP_OKAY);
		rdCheck(8'h18, 32'h0, RESP_SLVERR);
		axiWrite(8'h1c, 32'hffffffff, r);
		checkVal({30'h0, r}, {30'h0, RESP_SLVERR});
	endtask

	task automatic testMatch();
		speedRef <= 16'sh64;
		motorSpeed <= 16'sh6d;
		waitCyc(3);
		checkVal({28'h0, termOut_b}, 32'he);
		motorSpeed <= 16'sh6e;
		waitCyc(3);
		checkVal({28'h0, termOut_b}, 32'hf);
		motorSpeed <= 16'sh5b;
		waitCyc(3);
		checkVal({28'h0, termOut_b}, 32'he);
		wr(ADDR_LIMIT, 32'h0014000a);
		motorSpeed <= 16'sh77;
		waitCyc(3);
		checkVal({28'h0, termOut_b}, 32'he);
		wr(ADDR_ALLOC, 32'h200);
		waitCyc(3);
		checkVal({28'h0, termOut_b}, 32'hb);
		wr(ADDR_ALLOC, 32'h0);
		wr(ADDR_LIMIT, 32'h000a000a);
	endtask

	task automatic testClamp();
		speedRef <= 16'sh5;
		motorPos <= 32'sh64;
		ctlIn_b <= 4'he;
		waitCyc(3);
		checkVal({31'h0, holdEn}, 32'h0);
		wr(ADDR_ALLOC, 32'h1);
		waitCyc(3);
		checkVal({31'h0, holdEn}, 32'h1);
		motorPos <= 32'sh67;
		waitCyc(3);
		checkVal(holdCmd, 32'hfffffffd);
		speedRef <= 16'sha;
		waitCyc(3);
		checkVal({31'h0, holdEn}, 32'h0);
		speedRef <= 16'sh5;
		ctlIn_b <= 4'hb;
		wr(ADDR_ALLOC, 32'h30);
		waitCyc(3);
		checkVal({31'h0, holdEn}, 32'h1);
		ctlIn_b <= 4'hf;
		wr(ADDR_ALLOC, 32'h0);
	endtask

	task automatic testModeA();
		logic [31:0] d;
		logic [1:0] r;
		wr(ADDR_CTRL, 32'ha);
		auxCtlIn_b <= 1'b0;
		waitCyc(3);
		checkVal({31'h0, holdEn}, 32'h0);
		wr(ADDR_RESTART, 32'h1);
		waitCyc(3);
		checkVal({31'h0, holdEn}, 32'h1);
		axiRead(ADDR_STATUS, d, r);
		checkVal(d & 32'hf1, 32'ha1);
		auxCtlIn_b <= 1'b1;
		waitCyc(3);
		checkVal({31'h0, holdEn}, 32'h0);
	endtask

	task automatic testPos();
		int m;
		speedRef <= 16'sh0;
		motorSpeed <= 16'sh0;
		for (int f = 0; f < 5; f++) begin
			m = (f == 3) ? 2 : (f == 4) ? 4 : 1;
			setCfg(MODE_POS, form_e'(f), 2'h0);
			hostRun(form_e'(f), 1'b1, 2'h0, 8'h3);
			checkVal(posRef, 32'(3 * m));
			hostRun(form_e'(f), 1'b0, 2'h0, 8'h2);
			checkVal(posRef, 32'(m));
			motorPos <= 32'(m + 1);
			waitCyc(3);
			checkVal({28'h0, termOut_b}, 32'he);
			motorPos <= 32'(m + 2);
			waitCyc(3);
			checkVal({28'h0, termOut_b}, 32'hf);
		end
	endtask

	task automatic testInv();
		for (int v = 0; v < 4; v++) begin
			hostRun(FORM_DIR, 1'b1, 2'(v), 8'h0);
			setCfg(MODE_POS, FORM_DIR, 2'(v));
			hostRun(FORM_DIR, 1'b1, 2'(v), 8'h2);
			checkVal(posRef, 32'h2);
			hostRun(FORM_DIR, 1'b0, 2'(v), 8'h5);
			rdCheck(ADDR_POSREF, 32'hfffffffd, RESP_OKAY);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", samplesChecked, failCount);
		if (failCount == 0 && samplesChecked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Holds reset for 16 cycles, then runs every scenario.
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		testRegs();
		testMatch();
		testClamp();
		testModeA();
		testPos();
		testInv();
		summarize();
	end
endmodule
